// File: hdl/abn_filter.v
// Spike filter for one encoder input: a level passes after three steady samples.
// Assumes the input is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "qenc_defines.vh"
module abn_filter (
   // Clock and reset.
   input  wire clk,
   input  wire reset,
   // Raw and filtered level.
   input  wire din,
   output reg  dout
);
   reg [1:0] cnt_reg;

   // Count cycles the input differs from the output; switch at three.
   always @(posedge clk) begin
      if (reset) begin
         cnt_reg <= 2'h0;
         dout    <= 1'b0;
      end else if (din == dout) begin
         cnt_reg <= 2'h0;
      end else if (cnt_reg == `FILTER_LEN - 2'h1) begin
         cnt_reg <= 2'h0;
         dout    <= din;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
      end
   end
endmodule // abn_filter
`default_nettype wire

// File: hdl/enc_scaler.v
// Adds or subtracts the scaling constant to a 32.16 position accumulator.
// Assumes the caller presents one step request per cycle at most.
`timescale 1ns/1ps
`default_nettype none
module enc_scaler (
   // Current value.
   input  wire [31:0] pos_int,
   input  wire [15:0] pos_frac,
   // Scale and controls.
   input  wire [31:0] scale,
   input  wire        decimal,
   input  wire        down,
   // Next value.
   output reg  [31:0] next_int,
   output reg  [15:0] next_frac
);
   reg [16:0] f;
   reg [31:0] si;
   reg        carry;

   // Signed integer half plus fraction, binary or decimal wrap.
   always @* begin
      si    = {{16{scale[31]}}, scale[31:16]};
      carry = 1'b0;
      f     = 17'h0;
      if (!down) begin
         f = {1'b0, pos_frac} + {1'b0, scale[15:0]};
         if (decimal && f >= {1'b0, `DEC_WRAP}) begin
            f     = f - {1'b0, `DEC_WRAP};
            carry = 1'b1;
         end else if (!decimal) begin
            carry = f[16];
         end
         next_int  = pos_int + si + {31'h0, carry};
         next_frac = f[15:0];
      end else begin
         f = {1'b0, pos_frac} - {1'b0, scale[15:0]};
         if (f[16]) begin
            carry = 1'b1;
            if (decimal)
               f = f + {1'b0, `DEC_WRAP};
         end
         next_int  = pos_int - si - {31'h0, carry};
         next_frac = f[15:0];
      end
   end
endmodule // enc_scaler
`default_nettype wire

// File: hdl/qenc_defines.vh
// Constants for the quadrature encoder counter block.
// Assumes inclusion by bare name from the design files in hdl/.
`ifndef QENC_DEFINES_VH
`define QENC_DEFINES_VH
// Register byte offsets.
`define ADDR_GLOBAL_CONFIG 5'h00
`define ADDR_ENC_MODE      5'h04
`define ADDR_ENC_POS       5'h08
`define ADDR_ENC_CONST     5'h0c
`define ADDR_ENC_STATUS    5'h10
`define ADDR_ENC_LATCH     5'h14
`define ADDR_ENC_DEV       5'h18
`define ADDR_MOTOR_POS     5'h1c
// Global configuration bits.
`define GC_ENC_SEL   0
`define GC_STOP_EN   1
// Encoder mode bits.
`define EM_POL_A     0
`define EM_POL_B     1
`define EM_POL_N     2
`define EM_CLR_CONT  3
`define EM_CLR_ONCE  4
`define EM_CLR_ENC   5
`define EM_LATCH_ACT 6
`define EM_DECIMAL   7
// Status bits.
`define ST_N_EVENT   0
`define ST_DEV_WARN  1
// Reset values and constants.
`define ENC_CONST_RESET 32'h00010000
`define DEC_WRAP        16'h2710
`define FILTER_LEN      2'h3
`define ENN_OFF_CYCLES  2'h2
// AXI responses.
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// File: hdl/quadrature_encoder_counter.v
// Quadrature encoder counter with index handling, deviation check, stop pin.
// Assumes AXI4-Lite master on clk; encoder pins synchronous to clk.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "qenc_defines.vh"
module quadrature_encoder_counter (
   // Clock and reset.
   input  wire        clk,
   input  wire        reset,
   // AXI4-Lite write address and data.
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response.
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read.
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Encoder pins, A shared with the stop function, and the driver enable pin.
   input  wire        enc_a_stop_pin,
   input  wire        enc_b_pin,
   input  wire        enc_n_pin,
   input  wire        driver_enable_n,
   // Driver side.
   output reg         power_stage_on,
   output reg         step_halt,
   output reg         standstill_req,
   output reg         deviation_irq
);
   // Software registers.
   reg [1:0]  global_config_reg;
   reg [7:0]  encoder_mode_cfg_reg;
   reg [31:0] enc_const_reg;
   reg [31:0] enc_dev_reg;
   reg [31:0] motor_pos_reg;
   reg [31:0] pos_int_reg;
   reg [15:0] pos_frac_reg;
   reg [31:0] latch_reg;
   reg [1:0]  status_reg;
   // Filtered input history and enable pin cycle counter.
   reg        a_d_reg;
   reg        b_d_reg;
   reg        n_d_reg;
   reg [1:0]  enn_cnt_reg;
   // AXI write holding.
   reg        aw_got_reg;
   reg        w_got_reg;
   reg [4:0]  aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0]  w_strb_reg;

   // Filtered pin levels and the scaler's next position.
   wire       a_f;
   wire       b_f;
   wire       n_f;
   wire       stop_f;
   wire [31:0] next_int;
   wire [15:0] next_frac;

   // Encoder inputs reach the filters only when selected as encoder pins.
   // With stop enable set, A stops counting and the pin halts the driver.
   wire enc_sel  = global_config_reg[`GC_ENC_SEL];
   wire stop_en  = global_config_reg[`GC_STOP_EN];
   wire a_raw    = enc_sel & ~stop_en & enc_a_stop_pin;
   wire b_raw    = enc_sel & enc_b_pin;
   wire n_raw    = enc_sel & enc_n_pin;

   abn_filter u_fa (.clk(clk), .reset(reset), .din(a_raw), .dout(a_f));
   abn_filter u_fb (.clk(clk), .reset(reset), .din(b_raw), .dout(b_f));
   abn_filter u_fn (.clk(clk), .reset(reset), .din(n_raw), .dout(n_f));
   // The stop pin passes the same spike filter as the encoder lines.
   abn_filter u_fs (
      .clk  (clk),
      .reset(reset),
      .din  (enc_a_stop_pin),
      .dout (stop_f)
   );

   // Quadrature decode: one change per cycle counts, both changes ignored.
   // Two lines changing in one cycle mean a lost step, so nothing counts.
   wire a_chg = a_f ^ a_d_reg;
   wire b_chg = b_f ^ b_d_reg;
   wire step  = a_chg ^ b_chg;
   // With A leading B, A moves to differ from B; that is the up direction.
   wire down  = a_chg ? (a_f == b_f) : (b_f != a_f);

   // The scaler works out the next position for the present direction.
   enc_scaler u_scale (
      .pos_int  (pos_int_reg),
      .pos_frac (pos_frac_reg),
      .scale    (enc_const_reg),
      .decimal  (encoder_mode_cfg_reg[`EM_DECIMAL]),
      .down     (down),
      .next_int (next_int),
      .next_frac(next_frac)
   );

   // Index edge toward the active polarity, qualified by A and B levels.
   // Both edge terms use the current polarity, so a change of it is no edge.
   wire n_act   = n_f ^ ~encoder_mode_cfg_reg[`EM_POL_N];
   wire n_prev  = n_d_reg ^ ~encoder_mode_cfg_reg[`EM_POL_N];
   wire n_qual  = (a_f == encoder_mode_cfg_reg[`EM_POL_A]) &&
                  (b_f == encoder_mode_cfg_reg[`EM_POL_B]);
   wire n_armed = encoder_mode_cfg_reg[`EM_CLR_CONT] |
                  encoder_mode_cfg_reg[`EM_CLR_ONCE];
   wire n_event = n_act & ~n_prev & n_qual & n_armed;
   wire n_clear = n_event & encoder_mode_cfg_reg[`EM_CLR_ENC];

   // Deviation between motor and encoder positions.
   function [31:0] absdiff;
      input [31:0] x;
      input [31:0] y;
      reg   [31:0] d;
      begin
         d = x - y;
         absdiff = d[31] ? (32'h0 - d) : d;
      end
   endfunction

   // A zero limit switches the deviation check off.
   wire dev_hit = absdiff(pos_int_reg, motor_pos_reg) > enc_dev_reg &&
                  enc_dev_reg != 32'h0;

   // AXI write decode helpers.
   // A write commits once address and data are held and B is free.
   wire wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
   // Byte-lane merge of write data into the present word.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer      i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (be[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction
   wire [31:0] wmerged_cfg  = merge({30'h0, global_config_reg}, w_data_reg,
                                    w_strb_reg);
   wire [31:0] wmerged_mode = merge({24'h0, encoder_mode_cfg_reg},
                                    w_data_reg, w_strb_reg);
   // Every mapped offset but the read-only latch answers OKAY.
   wire wr_ok = aw_addr_reg == `ADDR_GLOBAL_CONFIG ||
                aw_addr_reg == `ADDR_ENC_MODE ||
                aw_addr_reg == `ADDR_ENC_POS ||
                aw_addr_reg == `ADDR_ENC_CONST ||
                aw_addr_reg == `ADDR_ENC_STATUS ||
                aw_addr_reg == `ADDR_ENC_DEV ||
                aw_addr_reg == `ADDR_MOTOR_POS;

   // AXI write channels: take address and data in either order.
   always @(posedge clk) begin
      if (reset) begin
         aw_got_reg    <= 1'b0;
         w_got_reg     <= 1'b0;
         aw_addr_reg   <= 5'h0;
         w_data_reg    <= 32'h0;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else begin
         // Each ready is a one-cycle pulse, raised the cycle after valid.
         s_axi_awready <= ~aw_got_reg & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_got_reg & ~s_axi_wready & s_axi_wvalid;
         // Whichever of address and data comes first is held for the other.
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg  <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Configuration registers written by software.
   always @(posedge clk) begin
      if (reset) begin
         global_config_reg    <= 2'h0;
         encoder_mode_cfg_reg <= 8'h0;
         enc_const_reg        <= `ENC_CONST_RESET;
         enc_dev_reg          <= 32'h0;
         motor_pos_reg        <= 32'h0;
      end else begin
         if (wr_fire && aw_addr_reg == `ADDR_GLOBAL_CONFIG)
            global_config_reg <= wmerged_cfg[1:0];
         // A single-shot index disarms itself unless the mode is written.
         if (wr_fire && aw_addr_reg == `ADDR_ENC_MODE)
            encoder_mode_cfg_reg <= wmerged_mode[7:0];
         else if (n_event && encoder_mode_cfg_reg[`EM_CLR_ONCE])
            encoder_mode_cfg_reg[`EM_CLR_ONCE] <= 1'b0;
         if (wr_fire && aw_addr_reg == `ADDR_ENC_CONST)
            enc_const_reg <= merge(enc_const_reg, w_data_reg, w_strb_reg);
         if (wr_fire && aw_addr_reg == `ADDR_ENC_DEV)
            enc_dev_reg <= merge(enc_dev_reg, w_data_reg, w_strb_reg);
         if (wr_fire && aw_addr_reg == `ADDR_MOTOR_POS)
            motor_pos_reg <= merge(motor_pos_reg, w_data_reg, w_strb_reg);
      end
   end

   // Position counter, latch and index status.
   always @(posedge clk) begin
      if (reset) begin
         a_d_reg      <= 1'b0;
         b_d_reg      <= 1'b0;
         n_d_reg      <= 1'b0;
         pos_int_reg  <= 32'h0;
         pos_frac_reg <= 16'h0;
         latch_reg    <= 32'h0;
         status_reg   <= 2'h0;
      end else begin
         a_d_reg <= a_f;
         b_d_reg <= b_f;
         n_d_reg <= n_f;
         // An index clear outranks a software write, which outranks a step.
         if (n_clear) begin
            pos_int_reg  <= 32'h0;
            pos_frac_reg <= 16'h0;
         end else if (wr_fire && aw_addr_reg == `ADDR_ENC_POS) begin
            pos_int_reg  <= merge(pos_int_reg, w_data_reg, w_strb_reg);
            pos_frac_reg <= 16'h0;
         end else if (step) begin
            pos_int_reg  <= next_int;
            pos_frac_reg <= next_frac;
         end
         // The latch takes the integer position standing at the event.
         if (n_event)
            latch_reg <= pos_int_reg;
         // Hardware set wins over a write-one-to-clear in the same cycle.
         if (wr_fire && aw_addr_reg == `ADDR_ENC_STATUS)
            status_reg <= status_reg & ~w_data_reg[1:0];
         if (n_clear)
            status_reg[`ST_N_EVENT] <= 1'b1;
         if (dev_hit)
            status_reg[`ST_DEV_WARN] <= 1'b1;
      end
   end

   // AXI read: one cycle to accept, data the next.
   always @(posedge clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (s_axi_araddr)
               `ADDR_GLOBAL_CONFIG: s_axi_rdata <= {30'h0, global_config_reg};
               `ADDR_ENC_MODE:   s_axi_rdata <= {24'h0, encoder_mode_cfg_reg};
               `ADDR_ENC_POS:    s_axi_rdata <= pos_int_reg;
               `ADDR_ENC_CONST:  s_axi_rdata <= enc_const_reg;
               `ADDR_ENC_STATUS: s_axi_rdata <= {30'h0, status_reg};
               `ADDR_ENC_LATCH:  s_axi_rdata <= latch_reg;
               `ADDR_ENC_DEV:    s_axi_rdata <= enc_dev_reg;
               `ADDR_MOTOR_POS:  s_axi_rdata <= motor_pos_reg;
               // Unmapped offsets read zero with an error response.
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Driver controls: stop pin, enable pin and deviation output.
   always @(posedge clk) begin
      if (reset) begin
         step_halt      <= 1'b0;
         standstill_req <= 1'b0;
         deviation_irq  <= 1'b0;
         power_stage_on <= 1'b0;
         enn_cnt_reg    <= 2'h0;
      end else begin
         // The halt follows the filtered stop pin while stop enable is set.
         step_halt      <= stop_en & stop_f;
         standstill_req <= stop_en & stop_f;
         deviation_irq  <= status_reg[`ST_DEV_WARN] | dev_hit;
         // Enable released: off at the next edge, inside the three allowed.
         if (driver_enable_n) begin
            enn_cnt_reg    <= 2'h0;
            power_stage_on <= 1'b0;
         end else if (enn_cnt_reg != `ENN_OFF_CYCLES) begin
            enn_cnt_reg <= enn_cnt_reg + 2'h1;
         end else begin
            power_stage_on <= 1'b1;
         end
      end
   end
endmodule // quadrature_encoder_counter
`default_nettype wire

// File: test/abn_encoder_model.sv
// Behavioural quadrature encoder with index line and spike injection.
// Assumes the bench pulses each request for one clock.
`timescale 1ns/1ps
`default_nettype none
module abn_encoder_model (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic reset,
   // Requests from the bench.
   input  wire logic step_req,
   input  wire logic step_up,
   input  wire logic index_req,
   input  wire logic glitch_req,
   // Encoder lines.
   output var  logic enc_a,
   output var  logic enc_b,
   output var  logic enc_n
);
   logic [1:0] phase_reg;
   logic [2:0] n_cnt_reg;
   logic [1:0] g_cnt_reg;
   // Levels stand until the bench asks for the next quarter step.
   always @(posedge clk) begin
      if (reset) begin
         phase_reg <= 2'h0;
         n_cnt_reg <= 3'h0;
         g_cnt_reg <= 2'h0;
      end else begin
         if (step_req)
            phase_reg <= step_up ? phase_reg + 2'h1 : phase_reg - 2'h1;
         n_cnt_reg <= index_req ? 3'h5 :
                      n_cnt_reg - {2'h0, n_cnt_reg != 3'h0};
         g_cnt_reg <= glitch_req ? 2'h2 :
                      g_cnt_reg - {1'h0, g_cnt_reg != 2'h0};
      end
   end
   // Gray order puts A ahead of B when counting up; a spike lasts 2 cycles.
   always_comb begin
      enc_a = (phase_reg[0] ^ phase_reg[1]) ^ (g_cnt_reg != 2'h0);
      enc_b = phase_reg[1];
      enc_n = n_cnt_reg != 3'h0;
   end
endmodule // abn_encoder_model
`default_nettype wire

// File: test/quadrature_encoder_counter_assertions.sv
// Checker for the encoder counter: bus timing, stop pin and enable pin.
// Assumes it is bound to the quadrature_encoder_counter module.
`timescale 1ns/1ps
`default_nettype none
module qenc_checker (
   // Clock, reset and bus handshakes.
   input wire logic       clk, reset,
   input wire logic       s_axi_awvalid, s_axi_awready,
   input wire logic       s_axi_wvalid, s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic       s_axi_bvalid, s_axi_bready,
   input wire logic       s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   // Pins and driver side.
   input wire logic       enc_a_stop_pin, driver_enable_n,
   input wire logic       power_stage_on, step_halt, standstill_req
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // A two-cycle spike on a quiet stop pin.
   sequence short_spike;
      !enc_a_stop_pin ##1 enc_a_stop_pin[*2] ##1 !enc_a_stop_pin;
   endsequence
   // Bus channels answer within the hand-over cycle counts.
   AST_AW_READY:
      assert property ($rose(s_axi_awvalid) |-> ##[1:3] s_axi_awready)
      else $error("write address not accepted in time");
   AST_B_AFTER_W:
      assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   AST_R_AFTER_AR:
      assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read data late");
   // Pins act on the driver side.
   AST_ENN_OFF:
      assert property (driver_enable_n[*3] |-> !power_stage_on)
      else $error("power stage still on after enable released");
   AST_HALT_SAME:
      assert property (step_halt == standstill_req)
      else $error("halt and standstill request differ");
   AST_HALT_LOW:
      assert property (!enc_a_stop_pin[*7] |-> !step_halt)
      else $error("halt while stop pin low");
   AST_HALT_RISE:
      assert property ($rose(step_halt) |->
                       $past(enc_a_stop_pin, 2) && $past(enc_a_stop_pin, 3))
      else $error("halt without a steady stop pin");
   AST_SPIKE:
      assert property (short_spike |-> (!step_halt)[*3])
      else $error("short spike raised halt");
   // Main scenarios.
   COV_HALT: cover property ($rose(step_halt));
   COV_ERR: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp[1]);
   COV_OFF: cover property ($fell(power_stage_on));
endmodule // qenc_checker
bind quadrature_encoder_counter qenc_checker i_checker (.clk, .reset,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .enc_a_stop_pin, .driver_enable_n,
   .power_stage_on, .step_halt, .standstill_req);
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the encoder counter with an encoder model.
// Assumes the design, its header, checker and model are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "qenc_defines.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   miscompares++; $display("unexpected %s: expected %h seen %h", nm, e, g); \
   end end
module tb;
   logic        clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, driver_enable_n;
   logic        step_req, step_up, index_req, glitch_req;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, enc_a_stop_pin, enc_b_pin, enc_n_pin;
   wire         power_stage_on, step_halt, standstill_req, deviation_irq;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   int          miscompares = 0, comparisons = 0, cycles = 0;
   // Design and the encoder on its far side.
   quadrature_encoder_counter i_dut (.clk, .reset, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .enc_a_stop_pin, .enc_b_pin, .enc_n_pin, .driver_enable_n,
      .power_stage_on, .step_halt, .standstill_req, .deviation_irq);
   abn_encoder_model i_enc (.clk, .reset, .step_req, .step_up, .index_req,
      .glitch_req, .enc_a(enc_a_stop_pin), .enc_b(enc_b_pin),
      .enc_n(enc_n_pin));
   // Clock of 8 ns and a cycle ceiling against hangs.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end
   // Prints the counts and the verdict, then stops.
   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Bus write: address and data offered together, response checked.
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clk);
      s_axi_bready <= 1'b0;
      `CHK("write response", er, s_axi_bresp)
      @(posedge clk);
   endtask
   // Bus read of one word, compared with the expected word.
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge clk);
      while (s_axi_arready !== 1'b1) @(posedge clk);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clk);
      s_axi_rready <= 1'b0;
      `CHK("read response", `RESP_OKAY, s_axi_rresp)
      `CHK("read data", e, s_axi_rdata)
      @(posedge clk);
   endtask
   // Encoder quarter steps, index pulses and spikes.
   task automatic enc_step(input logic up, input int n);
      repeat (n) begin
         step_req <= 1'b1;
         step_up <= up;
         @(posedge clk);
         step_req <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask
   task automatic pulse(input logic idx);
      index_req <= idx;
      glitch_req <= !idx;
      @(posedge clk);
      index_req <= 1'b0;
      glitch_req <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   // Reset values, a read-only latch and binary counting both ways.
   task automatic t_count;
      rd_chk(`ADDR_ENC_CONST, `ENC_CONST_RESET);
      axi_wr(`ADDR_ENC_LATCH, 32'h5, `RESP_SLVERR);
      enc_step(1'b1, 4);
      rd_chk(`ADDR_ENC_POS, 32'h0);
      axi_wr(`ADDR_GLOBAL_CONFIG, 32'h1, `RESP_OKAY);
      enc_step(1'b1, 4);
      rd_chk(`ADDR_ENC_POS, 32'h4);
      enc_step(1'b0, 2);
      rd_chk(`ADDR_ENC_POS, 32'h2);
      axi_wr(`ADDR_ENC_CONST, 32'hffff0000, `RESP_OKAY);
      enc_step(1'b1, 2);
      rd_chk(`ADDR_ENC_POS, 32'h0);
   endtask
   // Decimal constants 1.6 and -1.6 with fraction carry and borrow.
   task automatic t_decimal;
      axi_wr(`ADDR_ENC_MODE, 32'h80, `RESP_OKAY);
      axi_wr(`ADDR_ENC_CONST, 32'h00011770, `RESP_OKAY);
      enc_step(1'b1, 5);
      rd_chk(`ADDR_ENC_POS, 32'h8);
      axi_wr(`ADDR_ENC_CONST, 32'hfffe0fa0, `RESP_OKAY);
      enc_step(1'b1, 3);
      rd_chk(`ADDR_ENC_POS, 32'h3);
      enc_step(1'b0, 4);
      rd_chk(`ADDR_ENC_POS, 32'h9);
   endtask
   // Index in single-shot, qualified and continuous modes.
   task automatic t_index;
      axi_wr(`ADDR_ENC_MODE, 32'h34, `RESP_OKAY);
      axi_wr(`ADDR_ENC_CONST, 32'h00010000, `RESP_OKAY);
      axi_wr(`ADDR_ENC_POS, 32'h7, `RESP_OKAY);
      pulse(1'b1);
      rd_chk(`ADDR_ENC_POS, 32'h0);
      rd_chk(`ADDR_ENC_LATCH, 32'h7);
      rd_chk(`ADDR_ENC_STATUS, 32'h1);
      rd_chk(`ADDR_ENC_MODE, 32'h24);
      axi_wr(`ADDR_ENC_STATUS, 32'h1, `RESP_OKAY);
      rd_chk(`ADDR_ENC_STATUS, 32'h0);
      axi_wr(`ADDR_ENC_POS, 32'h5, `RESP_OKAY);
      pulse(1'b1);
      rd_chk(`ADDR_ENC_POS, 32'h5);
      axi_wr(`ADDR_ENC_MODE, 32'h2f, `RESP_OKAY);
      axi_wr(`ADDR_ENC_POS, 32'h9, `RESP_OKAY);
      pulse(1'b1);
      rd_chk(`ADDR_ENC_POS, 32'h9);
      enc_step(1'b1, 2);
      pulse(1'b1);
      rd_chk(`ADDR_ENC_LATCH, 32'hb);
      axi_wr(`ADDR_ENC_POS, 32'h6, `RESP_OKAY);
      pulse(1'b1);
      rd_chk(`ADDR_ENC_POS, 32'h0);
      axi_wr(`ADDR_ENC_MODE, 32'h0f, `RESP_OKAY);
      axi_wr(`ADDR_ENC_POS, 32'h4, `RESP_OKAY);
      pulse(1'b1);
      rd_chk(`ADDR_ENC_POS, 32'h4);
      enc_step(1'b0, 2);
      axi_wr(`ADDR_ENC_MODE, 32'h28, `RESP_OKAY);
      pulse(1'b1);
      rd_chk(`ADDR_ENC_POS, 32'h0);
   endtask
   // Stop pin, enable pin and deviation limit.
   task automatic t_pins;
      axi_wr(`ADDR_GLOBAL_CONFIG, 32'h3, `RESP_OKAY);
      pulse(1'b0);
      `CHK("halt after spike", 1'b0, step_halt)
      enc_step(1'b1, 1);
      `CHK("halt", 1'b1, step_halt)
      `CHK("standstill request", 1'b1, standstill_req)
      enc_step(1'b0, 1);
      `CHK("halt released", 1'b0, step_halt)
      driver_enable_n <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("power stage off", 1'b0, power_stage_on)
      driver_enable_n <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK("power stage on", 1'b1, power_stage_on)
      axi_wr(`ADDR_ENC_POS, 32'ha, `RESP_OKAY);
      axi_wr(`ADDR_MOTOR_POS, 32'h0, `RESP_OKAY);
      axi_wr(`ADDR_ENC_STATUS, 32'h3, `RESP_OKAY);
      axi_wr(`ADDR_ENC_DEV, 32'h3, `RESP_OKAY);
      repeat (8) @(posedge clk);
      `CHK("deviation interrupt", 1'b1, deviation_irq)
      rd_chk(`ADDR_ENC_STATUS, 32'h2);
      axi_wr(`ADDR_MOTOR_POS, 32'ha, `RESP_OKAY);
      axi_wr(`ADDR_ENC_STATUS, 32'h2, `RESP_OKAY);
      repeat (8) @(posedge clk);
      `CHK("deviation cleared", 1'b0, deviation_irq)
   endtask
   // Reset for 16 cycles, then the scenarios in order.
   initial begin
      {reset, driver_enable_n} = 2'h2;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 12'h0;
      {step_req, step_up, index_req, glitch_req} = 4'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_count();
      t_decimal();
      t_index();
      t_pins();
      close_out();
   end
endmodule // tb
`default_nettype wire
